// >>> ccp_pin_ctrl.sv
// pin control, alarm routing and serial port muxing of the clock chip
// Operation
// (R01) reset low returns all logic and config to defaults
// (R02) output clock disabled while reset held
// (R03) host programs config after reset before expecting output clock
// (R04) interrupt route bit set makes alarm pin a maskable irq, polarity bit
// (R05) loss route alone makes alarm pin show input loss, its polarity bit
// (R06) no function routed tristates the alarm pin
// (R07) lock pin enable set drives unlock state, high means unlocked; here only with unlock_polarity set, else high means locked
// (R08) lock pin disabled tristates it; enabled level follows lock polarity
// (R09) unlock status bit always shows current lock state
// (R10) source select low picks input clock, high picks crystal
// (R11) host always drives source select to a defined level
// (R12) protocol strap low is i2c, high is spi
// (R13) serial clock pin is serial clock in both modes; serial_clock is not used by this block
// (R14) data pin bidirectional in i2c, output only in spi
// (R15) i2c target address is 1101 then three address straps
// (R16) spi mode ignores the two lower address straps
// (R17) shared pin is address bit 2 in i2c, select in spi
// (R18) data in pin ignored in i2c, spi data input in spi
// (R19) two three-level rate straps default mid; both high unsupported
// (R20) format field picks output format; cmos drives both pins alike
// (R21) monitor selected input, raise loss alarm on missing pulses
// (R22) routed irq asserts while any unmasked pending alarm stays set
`timescale 1ns/100ps
`include "ccp_params.svh"
module ccp_pin_ctrl #(
    parameter int LOS_CYCLES = `CCP_LOS_CYCLES,
    parameter int NUM_ALARMS = 2
) (
    input  wire logic                  mclk,
    input  wire logic                  reset_n,
    input  wire logic                  input_clock,
    input  wire logic                  crystal_pin_a,
    input  wire logic                  pll_clock,
    input  wire logic                  pll_unlocked,
    input  wire logic                  source_select,
    input  wire logic                  irq_route_enable,
    input  wire logic                  irq_polarity,
    input  wire logic                  input_loss_route_enable,
    input  wire logic                  input_loss_polarity,
    input  wire logic                  unlock_pin_enable,
    input  wire logic                  unlock_polarity,
    input  wire logic [NUM_ALARMS-1:0] alarm_mask,
    input  wire logic [NUM_ALARMS-1:0] alarm_clear,
    input  wire logic                  config_done,
    input  wire ccp_pkg::ccp_fmt_t     output_format_field,
    input  wire ccp_pkg::ccp_rate_t    ref_rate_strap_0,
    input  wire ccp_pkg::ccp_rate_t    ref_rate_strap_1,
    input  wire logic                  port_protocol_strap,
    input  wire logic                  serial_clock,
    input  wire logic                  target_addr_bit0,
    input  wire logic                  target_addr_bit1,
    input  wire logic                  addr_bit2_or_select,
    input  wire logic                  serial_data_in,
    input  wire logic                  serial_data_io_in,
    input  wire logic                  core_sda_drive_low,
    input  wire logic                  core_sdo_bit,
    output logic                       serial_data_io_out,
    output logic                       serial_data_io_oe_n,
    output logic                       spi_mode,
    output logic [6:0]                 i2c_target_addr,
    output logic                       spi_select_n,
    output logic                       spi_data_in,
    output logic                       i2c_data_in,
    output logic                       pll_ref_is_xtal,
    output logic                       rate_strap_error,
    output logic [3:0]                 rate_code,
    output logic                       output_clock_p,
    output logic                       output_clock_n,
    output logic                       output_clock_oe_n,
    output logic                       alarm_or_irq_out,
    output logic                       alarm_or_irq_oe_n,
    output logic                       unlock_indicator_out,
    output logic                       unlock_indicator_oe_n,
    output logic                       unlock_status_bit,
    output logic                       input_loss_status,
    output logic [NUM_ALARMS-1:0]      alarm_pending
);

// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
logic [1:0] sel_sync_reg;
logic [1:0] lol_sync_reg;
logic [1:0] mode_sync_reg;
logic [1:0] ss_sync_reg;
logic [1:0] cfg_sync_reg;
// (R11) source select sampled, never floating
always_ff @(posedge mclk or negedge reset_n)
begin
    if (!reset_n)
    begin
        sel_sync_reg  <= 2'h0;
        lol_sync_reg  <= 2'h3;
        mode_sync_reg <= 2'h0;
        ss_sync_reg   <= 2'h3;
        cfg_sync_reg  <= 2'h0;
    end
    else
    begin
        sel_sync_reg  <= {sel_sync_reg[0], source_select};
        lol_sync_reg  <= {lol_sync_reg[0], pll_unlocked};
        mode_sync_reg <= {mode_sync_reg[0], port_protocol_strap};
        ss_sync_reg   <= {ss_sync_reg[0], addr_bit2_or_select};
        cfg_sync_reg  <= {cfg_sync_reg[0], config_done};
    end
end

// ----------------------------------------------------------------
// straps caught after reset release
// ----------------------------------------------------------------
// wait until the synchronisers hold the strap levels, not their reset values
logic [1:0] strap_wait_reg;
logic       mode_reg;
logic [2:0] addr_lo_reg;
always_ff @(posedge mclk or negedge reset_n)
begin
    if (!reset_n)
    begin
        strap_wait_reg <= 2'h0;
        mode_reg       <= `CCP_PROTO_I2C;
        addr_lo_reg    <= 3'h0;
    end
    else if (strap_wait_reg != 2'h3)
    begin
        strap_wait_reg <= strap_wait_reg + 2'h1;
        if (strap_wait_reg == 2'h2)
        begin
            // (R12) protocol strap latch
            mode_reg    <= mode_sync_reg[1];
            // (R15) address straps latch
            addr_lo_reg <= {ss_sync_reg[1], target_addr_bit1, target_addr_bit0};
        end
    end
end

// (R15) i2c address build
assign i2c_target_addr = {`CCP_ADDR_UPPER, addr_lo_reg};
assign spi_mode        = mode_reg;
// (R16) (R17) select only in spi mode
assign spi_select_n    = (mode_reg == `CCP_PROTO_SPI) ? ss_sync_reg[1] : 1'b1;

// ----------------------------------------------------------------
// serial pins (serial_clock is not used by this block)
// ----------------------------------------------------------------
// (R13) serial_clock enters this block but no logic here uses it in either mode
// (R18) data in only used in spi
assign spi_data_in = (mode_reg == `CCP_PROTO_SPI) ? serial_data_in : 1'b0;
// (R14) data pin role by mode
assign i2c_data_in = (mode_reg == `CCP_PROTO_I2C) ? serial_data_io_in : 1'b1;
always_comb
begin
    if (mode_reg == `CCP_PROTO_SPI)
    begin
        serial_data_io_out  = core_sdo_bit;
        serial_data_io_oe_n = ss_sync_reg[1];
    end
    else
    begin
        serial_data_io_out  = 1'b0;
        serial_data_io_oe_n = !core_sda_drive_low;
    end
end

// ----------------------------------------------------------------
// reference select and rate straps
// ----------------------------------------------------------------
// (R10) reference source choice
assign pll_ref_is_xtal  = (sel_sync_reg[1] == `CCP_SRC_XTAL);
// (R19) both-high combination flagged
assign rate_strap_error = (ref_rate_strap_0 == ccp_pkg::CCP_RATE_H_E) &&
                          (ref_rate_strap_1 == ccp_pkg::CCP_RATE_H_E);
assign rate_code        = {ref_rate_strap_1, ref_rate_strap_0};

// ----------------------------------------------------------------
// loss of signal monitor on link clock or crystal, whichever is selected
// ----------------------------------------------------------------
logic sel_link_s0_reg;
logic sel_link_s1_reg;
logic mon_tog_reg;
always_ff @(posedge input_clock or negedge reset_n)
begin
    if (!reset_n)
        mon_tog_reg <= 1'b0;
    else
        mon_tog_reg <= !mon_tog_reg;
end
logic xtal_tog_reg;
always_ff @(posedge crystal_pin_a or negedge reset_n)
begin
    if (!reset_n)
        xtal_tog_reg <= 1'b0;
    else
        xtal_tog_reg <= !xtal_tog_reg;
end
logic [2:0] tog_sync_reg;
logic [2:0] xtog_sync_reg;
logic [15:0] los_cnt_reg;
logic        los_reg;
logic        edge_seen;
always_ff @(posedge mclk or negedge reset_n)
begin
    if (!reset_n)
    begin
        tog_sync_reg  <= 3'h0;
        xtog_sync_reg <= 3'h0;
    end
    else
    begin
        tog_sync_reg  <= {tog_sync_reg[1:0], mon_tog_reg};
        xtog_sync_reg <= {xtog_sync_reg[1:0], xtal_tog_reg};
    end
end
assign edge_seen = pll_ref_is_xtal ? (xtog_sync_reg[2] != xtog_sync_reg[1])
                                   : (tog_sync_reg[2] != tog_sync_reg[1]);
// (R21) missing pulse timeout
always_ff @(posedge mclk or negedge reset_n)
begin
    if (!reset_n)
    begin
        los_cnt_reg <= 16'h0;
        los_reg     <= 1'b0;
    end
    else if (edge_seen)
    begin
        los_cnt_reg <= 16'h0;
        los_reg     <= 1'b0;
    end
    else if (los_cnt_reg >= 16'(LOS_CYCLES - 1))
        los_reg <= 1'b1;
    else
        los_cnt_reg <= los_cnt_reg + 16'h1;
end
assign input_loss_status = los_reg;
// (R09) lock state always visible
assign unlock_status_bit = lol_sync_reg[1];

// ----------------------------------------------------------------
// sticky alarms for interrupt
// ----------------------------------------------------------------
logic [NUM_ALARMS-1:0] alarm_event;
logic [NUM_ALARMS-1:0] pend_reg;
assign alarm_event = NUM_ALARMS'({lol_sync_reg[1], los_reg});
// set wins over clear
always_ff @(posedge mclk or negedge reset_n)
begin
    if (!reset_n)
        pend_reg <= '0;
    else
        pend_reg <= (pend_reg & ~alarm_clear) | alarm_event;
end
assign alarm_pending = pend_reg;

// ----------------------------------------------------------------
// alarm and unlock pins
// ----------------------------------------------------------------
logic irq_active;
// (R22) any unmasked pending alarm
assign irq_active = |(pend_reg & ~alarm_mask);
always_comb
begin
    // (R04) irq route has priority
    if (irq_route_enable)
    begin
        alarm_or_irq_out  = irq_active ^ !irq_polarity;
        alarm_or_irq_oe_n = 1'b0;
    end
    // (R05) input loss route
    else if (input_loss_route_enable)
    begin
        alarm_or_irq_out  = los_reg ^ !input_loss_polarity;
        alarm_or_irq_oe_n = 1'b0;
    end
    // (R06) nothing routed
    else
    begin
        alarm_or_irq_out  = 1'b0;
        alarm_or_irq_oe_n = 1'b1;
    end
end
// (R07) (R08) unlock pin drive and polarity
assign unlock_indicator_out  = unlock_pin_enable ? (lol_sync_reg[1] ^ !unlock_polarity) : 1'b0;
assign unlock_indicator_oe_n = !unlock_pin_enable;

// ----------------------------------------------------------------
// output clock gating and format
// ----------------------------------------------------------------
// (R01) (R02) (R03) off in reset and until configured
assign output_clock_oe_n = !(reset_n && cfg_sync_reg[1]);
assign output_clock_p    = output_clock_oe_n ? 1'b0 : pll_clock;
// (R20) cmos drives both pins alike
assign output_clock_n    = output_clock_oe_n ? 1'b0 :
    ((output_format_field == ccp_pkg::CCP_FMT_CMOS_E) ? pll_clock : !pll_clock);

// ----------------------------------------------------------------
// assertions
// ----------------------------------------------------------------
// (R06)
tristate_alarm_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (!irq_route_enable && !input_loss_route_enable) |-> alarm_or_irq_oe_n) // (R06)
    else $error("alarm pin not tristated");
los_raise_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (los_cnt_reg >= 16'(LOS_CYCLES - 1) && !edge_seen) |=> los_reg) // (R21)
    else $error("loss alarm not raised");
irq_level_a: assert property (@(posedge mclk) disable iff (!reset_n)
    irq_route_enable |-> (alarm_or_irq_out == (irq_active == irq_polarity))) // (R04)
    else $error("irq pin level wrong");
los_pin_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (!irq_route_enable && input_loss_route_enable)
    |-> (!alarm_or_irq_oe_n && alarm_or_irq_out == (los_reg == input_loss_polarity))) // (R05)
    else $error("loss pin level wrong");
unlock_pin_a: assert property (@(posedge mclk) disable iff (!reset_n)
    unlock_pin_enable |-> (unlock_indicator_out == (unlock_status_bit == unlock_polarity))) // (R07)
    else $error("unlock pin level wrong");
unlock_tri_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !unlock_pin_enable |-> unlock_indicator_oe_n) // (R08)
    else $error("unlock pin not tristated");
lock_status_a: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(lol_sync_reg[0]) |=> unlock_status_bit) // (R09)
    else $error("lock status lags");
irq_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (alarm_event[0] && !alarm_mask[0])
    |=> (alarm_pending[0] && (alarm_mask[0] || irq_active))) // (R22)
    else $error("irq lost an alarm");
cmos_same_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (!output_clock_oe_n && output_format_field == ccp_pkg::CCP_FMT_CMOS_E)
    |-> (output_clock_p == output_clock_n)) // (R20)
    else $error("cmos outputs differ");
spi_ignore_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (mode_reg == `CCP_PROTO_I2C) |-> (spi_data_in == 1'b0 && spi_select_n)) // (R18)
    else $error("spi inputs leak in i2c");

endmodule // ccp_pin_ctrl

// >>> ccp_params.svh
// constants for the clock chip pin control block
`ifndef CCP_PARAMS_SVH
`define CCP_PARAMS_SVH
`define CCP_ADDR_UPPER      4'hd
`define CCP_LOS_TIME_NS     1000
`define CCP_MCLK_PERIOD_NS  50
`define CCP_LOS_CYCLES      ((`CCP_LOS_TIME_NS + `CCP_MCLK_PERIOD_NS - 1) / `CCP_MCLK_PERIOD_NS)
`define CCP_PROTO_I2C       1'b0
`define CCP_PROTO_SPI       1'b1
`define CCP_SRC_INPUT_CLOCK        1'b0
`define CCP_SRC_XTAL        1'b1
`define CCP_RATE_LOW        2'h0
`define CCP_RATE_MID        2'h1
`define CCP_RATE_HIGH       2'h2
`define CCP_FMT_CMOS        2'h3
`endif

// >>> ccp_pkg.sv
// types for the clock chip pin control block
package ccp_pkg;
    typedef enum logic [1:0] {
        CCP_FMT_LVPECL_E = 2'h0,
        CCP_FMT_LVDS_E   = 2'h1,
        CCP_FMT_CML_E    = 2'h2,
        CCP_FMT_CMOS_E   = 2'h3
    } ccp_fmt_t;
    typedef enum logic [1:0] {
        CCP_RATE_L_E = 2'h0,
        CCP_RATE_M_E = 2'h1,
        CCP_RATE_H_E = 2'h2
    } ccp_rate_t;
endpackage

// >>> ccp_far_model.sv
// far side model: monitored input clock, serial clock tied low and open-drain data line
`timescale 1ns/100ps
module ccp_far_model (
    input  wire logic run,
    input  wire logic host_sda_low,
    input  wire logic serial_data_io_out,
    input  wire logic serial_data_io_oe_n,
    output logic      input_clock,
    output logic      serial_clock,
    output logic      serial_data_io_in
);
    // ------------------------------------------------------------
    // link clock, stands still low while stopped
    // ------------------------------------------------------------
    initial
    begin
        input_clock = 1'b0;
        serial_clock = 1'b0;
        #3.3;
        forever
        begin
            #80 input_clock = run ? ~input_clock : 1'b0;
        end
    end
    // line with pull-up, any low driver wins
    assign serial_data_io_in = !(host_sda_low || (!serial_data_io_oe_n && !serial_data_io_out));
endmodule // ccp_far_model

// >>> ccp_pin_ctrl_tb_top.sv
// testbench for the clock chip pin control block
`timescale 1ns/100ps
module ccp_pin_ctrl_tb_top;
    logic mclk, reset_n, pll_clock, pll_unlocked, source_select, config_done, run;
    logic irq_route_enable, irq_polarity, input_loss_route_enable, input_loss_polarity;
    logic unlock_pin_enable, unlock_polarity, port_protocol_strap, host_sda_low;
    logic target_addr_bit0, target_addr_bit1, addr_bit2_or_select, serial_data_in;
    logic core_sda_drive_low, core_sdo_bit, crystal_pin_a;
    logic input_clock, serial_clock, serial_data_io_in, serial_data_io_out, serial_data_io_oe_n;
    logic spi_mode, spi_select_n, spi_data_in, i2c_data_in, pll_ref_is_xtal, rate_strap_error;
    logic output_clock_p, output_clock_n, output_clock_oe_n, alarm_or_irq_out, alarm_or_irq_oe_n;
    logic unlock_indicator_out, unlock_indicator_oe_n, unlock_status_bit, input_loss_status;
    logic [1:0] alarm_mask, alarm_clear, alarm_pending;
    logic [6:0] i2c_target_addr;
    logic [3:0] rate_code;
    ccp_pkg::ccp_fmt_t  output_format_field;
    ccp_pkg::ccp_rate_t ref_rate_strap_0, ref_rate_strap_1;
    int fail_count, compares, cycles;

    ccp_pin_ctrl #(.LOS_CYCLES(4), .NUM_ALARMS(2)) DUT (.mclk, .reset_n, .input_clock,
        .crystal_pin_a, .pll_clock, .pll_unlocked, .source_select, .irq_route_enable,
        .irq_polarity, .input_loss_route_enable, .input_loss_polarity, .unlock_pin_enable,
        .unlock_polarity, .alarm_mask, .alarm_clear, .config_done, .output_format_field,
        .ref_rate_strap_0, .ref_rate_strap_1, .port_protocol_strap, .serial_clock,
        .target_addr_bit0, .target_addr_bit1, .addr_bit2_or_select, .serial_data_in,
        .serial_data_io_in, .core_sda_drive_low, .core_sdo_bit, .serial_data_io_out,
        .serial_data_io_oe_n, .spi_mode, .i2c_target_addr, .spi_select_n, .spi_data_in,
        .i2c_data_in, .pll_ref_is_xtal, .rate_strap_error, .rate_code, .output_clock_p,
        .output_clock_n, .output_clock_oe_n, .alarm_or_irq_out, .alarm_or_irq_oe_n,
        .unlock_indicator_out, .unlock_indicator_oe_n, .unlock_status_bit,
        .input_loss_status, .alarm_pending);
    ccp_far_model far (.run, .host_sda_low, .serial_data_io_out, .serial_data_io_oe_n,
        .input_clock, .serial_clock, .serial_data_io_in);

    // ------------------------------------------------------------
    // clocks, timeout and helpers
    // ------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial
    begin
        pll_clock = 1'b0;
        #0.3;
        forever #10 pll_clock = ~pll_clock;
    end
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            print_verdict();
        end
    end
    task automatic at(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic look(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial
    begin
        reset_n = 0; run = 0; config_done = 0; pll_unlocked = 0; crystal_pin_a = 0;
        irq_route_enable = 0; irq_polarity = 0; input_loss_route_enable = 0;
        input_loss_polarity = 0; unlock_pin_enable = 0; unlock_polarity = 0;
        port_protocol_strap = 0; host_sda_low = 0; target_addr_bit0 = 1;
        target_addr_bit1 = 0; addr_bit2_or_select = 1; serial_data_in = 1;
        core_sda_drive_low = 0; core_sdo_bit = 0; alarm_mask = 0; alarm_clear = 0;
        output_format_field = ccp_pkg::CCP_FMT_CMOS_E;
        ref_rate_strap_0 = ccp_pkg::CCP_RATE_M_E; ref_rate_strap_1 = ccp_pkg::CCP_RATE_M_E;
        source_select = 0;
        look(3);
        chk(output_clock_oe_n, 1);
        chk(alarm_pending, 0);
        chk(input_loss_status, 0);
        at(1); reset_n <= 1; run <= 1;
        look(4);
        chk(output_clock_oe_n, 1);
        chk(spi_mode, 0);
        chk(i2c_target_addr, 7'h6d);
        chk(spi_data_in, 0);
        chk(i2c_data_in, 1);
        chk(serial_data_io_oe_n, 1);
        at(1); core_sda_drive_low <= 1;
        look(1);
        chk(serial_data_io_oe_n, 0);
        chk(serial_data_io_out, 0);
        at(1); core_sda_drive_low <= 0; host_sda_low <= 1;
        look(1);
        chk(i2c_data_in, 0);
        at(1); host_sda_low <= 0; config_done <= 1;
        look(4);
        chk(output_clock_oe_n, 0);
        for (int i = 0; i < 12; i++)
        begin
            if (i == 6) output_format_field <= ccp_pkg::CCP_FMT_LVDS_E;
            look(1);
            chk(output_clock_p, pll_clock);
            chk(output_clock_n, (i < 6) ? pll_clock : !pll_clock);
        end
        for (int i = 0; i < 3; i++)
        begin
            at(1); source_select <= i[0];
            look(3);
            chk(pll_ref_is_xtal, i[0]);
        end
        for (int i = 0; i < 5; i++)
        begin
            at(1); unlock_pin_enable <= (i < 4); unlock_polarity <= i[0]; pll_unlocked <= i[1];
            look(3);
            chk(unlock_indicator_oe_n, i == 4);
            if (i < 4) chk(unlock_indicator_out, i[0] ? i[1] : !i[1]);
            chk(unlock_status_bit, i[1]);
        end
        at(1); alarm_clear <= 2'h3;
        look(2);
        chk(alarm_or_irq_oe_n, 1);
        at(1); alarm_clear <= 2'h0; input_loss_route_enable <= 1; input_loss_polarity <= 1;
        look(2);
        chk(alarm_or_irq_oe_n, 0);
        chk(alarm_or_irq_out, 0);
        at(1); run <= 0;
        look(12);
        chk(input_loss_status, 1);
        chk(alarm_or_irq_out, 1);
        at(1); input_loss_polarity <= 0;
        look(1);
        chk(alarm_or_irq_out, 0);
        at(1); irq_route_enable <= 1; irq_polarity <= 1; alarm_mask <= 2'h2;
        look(2);
        chk(alarm_pending[0], 1);
        chk(alarm_or_irq_out, 1);
        at(1); alarm_mask <= 2'h3;
        look(2);
        chk(alarm_or_irq_out, 0);
        at(1); run <= 1; irq_polarity <= 0;
        look(10);
        chk(input_loss_status, 0);
        at(1); alarm_clear <= 2'h3;
        at(1); alarm_clear <= 2'h0; alarm_mask <= 2'h0;
        look(1);
        chk(alarm_pending, 0);
        chk(alarm_or_irq_out, 1);
        at(1); pll_unlocked <= 1;
        look(5);
        chk(alarm_pending[1], 1);
        chk(alarm_or_irq_out, 0);
        for (int i = 0; i < 9; i++)
        begin
            at(1);
            ref_rate_strap_0 <= ccp_pkg::ccp_rate_t'(i % 3);
            ref_rate_strap_1 <= ccp_pkg::ccp_rate_t'(i / 3);
            look(1);
            chk(rate_strap_error, i == 8);
            chk(rate_code, {2'(i / 3), 2'(i % 3)});
        end
        at(1); reset_n <= 0; port_protocol_strap <= 1;
        look(2);
        chk(output_clock_oe_n, 1);
        chk(alarm_pending, 0);
        at(1); reset_n <= 1;
        look(3);
        chk(spi_mode, 1);
        chk(spi_select_n, 1);
        chk(i2c_data_in, 1);
        chk(spi_data_in, 1);
        at(1); addr_bit2_or_select <= 0; core_sdo_bit <= 1; serial_data_in <= 0;
        look(3);
        chk(spi_select_n, 0);
        chk(serial_data_io_oe_n, 0);
        chk(serial_data_io_out, 1);
        chk(spi_data_in, 0);
        print_verdict();
    end
endmodule // ccp_pin_ctrl_tb_top
